// *** design/dsync_map.svh ***
// Constants for the downstream sync timestamp path.
`ifndef DSYNC_MAP_SVH
`define DSYNC_MAP_SVH
`define DSYNC_PKT_LEN        8'd188
`define DSYNC_SYNC_BYTE      8'h47
`define DSYNC_PTR_IDX        8'd4
`define DSYNC_MSG_IDX        8'd5
`define DSYNC_MSG_TAG        16'h00c0
`define DSYNC_MSG_TAG_HI     8'h00
`define DSYNC_MSG_TAG_LO     8'hc0
`define DSYNC_TS_IDX         8'd24
`define DSYNC_NULL_PID_HI    8'h1f
`define DSYNC_NULL_PID_LO    8'hff
`define DSYNC_CLK_MHZ        40
`define DSYNC_MCLK_KHZ       10240
`define DSYNC_MCLK_ACC       16'd10240
`define DSYNC_MCLK_MOD       16'd40000
`define DSYNC_LAG_MAX        8'd100
`define DSYNC_LATENCY_US     200
`define DSYNC_LATENCY_CYC    (`DSYNC_LATENCY_US * `DSYNC_CLK_MHZ)
`define DSYNC_SKEW_US        500
`define DSYNC_SKEW_CYC       (`DSYNC_SKEW_US * `DSYNC_CLK_MHZ)
`define DSYNC_DATA_BUF_MS    8
`define DSYNC_VIDEO_BUF_MS   10
`define DSYNC_INTERVAL_RST   32'd400000
`endif

// *** design/dsync_pkg.sv ***
// Types shared by both ends of the downstream sync timestamp path.
package dsync_pkg;
   typedef enum logic [1:0] {
      DSYNC_MODE_PASSTHRU = 2'b00,
      DSYNC_MODE_MULTI    = 2'b01,
      DSYNC_MODE_STREAM   = 2'b10
   } dsync_mode_t;
   typedef enum logic [1:0] {
      DSYNC_ST_IDLE = 2'b00,
      DSYNC_ST_FWD  = 2'b01,
      DSYNC_ST_INS  = 2'b10,
      DSYNC_ST_NULL = 2'b11
   } dsync_state_t;
endpackage : dsync_pkg

// *** design/dsync_if.sv ***
// Transport byte stream from headend core to remote node.
`timescale 1ns/1ps
interface dsync_if;
   logic       valid;
   logic       ready;
   logic       sop;
   logic [7:0] data;
   modport headend (output valid, output sop, output data, input ready);
   modport node    (input valid, input sop, input data, output ready);
endinterface : dsync_if

// *** design/dsync_headend.sv ***
// Headend core end: emits transport packets with zeroed sync stamps.
`timescale 1ns/1ps
`include "dsync_map.svh"
module dsync_headend (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_pkt_valid,
   input  wire logic        i_pkt_is_sync,
   input  wire logic [7:0]  i_pkt_byte,
   input  wire logic        i_pkt_sop,
   output logic             o_pkt_ready,
   dsync_if.headend         lnk
);
   logic [7:0] idx_reg;
   logic       valid_reg;
   logic       sop_reg;
   logic [7:0] data_reg;
   logic       sk_valid_reg;
   logic       sk_sop_reg;
   logic [7:0] sk_data_reg;
   logic       rdy_reg;
   logic       is_sync_reg;
   logic       take;
   logic       out_free;
   logic       stream_mode;
   logic [7:0] byte_in;

   assign stream_mode = (i_mode == dsync_pkg::DSYNC_MODE_STREAM);
   assign take = i_pkt_valid && rdy_reg;
   assign out_free = !valid_reg || lnk.ready;
   assign lnk.valid = valid_reg;
   assign lnk.sop = sop_reg;
   assign lnk.data = data_reg;
   assign o_pkt_ready = rdy_reg;

   // One skid byte lets ready stay registered though the node stalls at once.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         rdy_reg <= 1'b0;
      end else begin
         rdy_reg <= out_free || !(take || sk_valid_reg);
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         idx_reg     <= 8'h00;
         is_sync_reg <= 1'b0;
      end else if (take) begin
         if (i_pkt_sop) begin
            idx_reg     <= 8'h01;
            is_sync_reg <= i_pkt_is_sync && !stream_mode; // [RL11]
         end else begin
            idx_reg <= idx_reg + 8'h01;
         end
      end
   end

   // Sync packets get the tag after the pointer and a zero stamp.
   always_comb begin
      byte_in = i_pkt_byte;
      if (i_pkt_sop) begin
         if (i_pkt_is_sync && !stream_mode) begin
            byte_in = `DSYNC_SYNC_BYTE;
         end
      end else if (is_sync_reg) begin
         if (idx_reg == `DSYNC_PTR_IDX) begin
            byte_in = 8'h00; // [RL7] [RL8]
         end else if (idx_reg == `DSYNC_MSG_IDX) begin
            byte_in = `DSYNC_MSG_TAG_LO; // [RL8]
         end else if (idx_reg >= `DSYNC_TS_IDX &&
                      idx_reg < `DSYNC_TS_IDX + 8'd4) begin
            byte_in = 8'h00; // [RL10]
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         sk_valid_reg <= 1'b0;
         sk_sop_reg   <= 1'b0;
         sk_data_reg  <= 8'h00;
      end else if (out_free) begin
         sk_valid_reg <= 1'b0;
      end else if (take) begin
         sk_valid_reg <= 1'b1;
         sk_sop_reg   <= i_pkt_sop;
         sk_data_reg  <= byte_in;
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         valid_reg <= 1'b0;
         sop_reg   <= 1'b0;
         data_reg  <= 8'h00;
      end else if (out_free) begin
         if (sk_valid_reg) begin
            valid_reg <= 1'b1;
            sop_reg   <= sk_sop_reg;
            data_reg  <= sk_data_reg;
         end else if (take) begin
            valid_reg <= 1'b1;
            sop_reg   <= i_pkt_sop;
            data_reg  <= byte_in;
         end else begin
            valid_reg <= 1'b0;
            sop_reg   <= 1'b0;
         end
      end
   end
   // Constant rate and null padding are the feeder's duty. [RL16] [RL17]
endmodule : dsync_headend

// *** design/dsync_node.sv ***
// Remote node end: stamps and inserts sync packets and pads nulls on the stream.
// Rules of the document for this path
// RL1: Keep local timestamp from timing interface.
// RL2: Rewrite stamps of embedded sync messages.
// RL3: Streaming mode inserts own sync messages.
// RL4: Message at sixth byte, pointer fifth.
// RL5: Timebase lags reference 0 to 100 cycles.
// RL6: Stamp equals count at first byte out.
// RL7: Headend generates sync in passthrough mode.
// RL8: Headend places sync at sixth byte.
// RL9: Detect by start flag and 0x00c0.
// RL10: Headend stamp may be zero.
// RL11: Headend sends no sync when streaming.
// RL12: Isolated packet latency under 200 us.
// RL13: Bonded channel skew under 500 us.
// RL14: Data channel buffers 8 ms traffic.
// RL15: Video channel buffers 10 ms traffic.
// RL16: Headend sends constant rate padded stream.
// RL17: Headend rate matches configured channel rate.
// RL18: Synchronous mode supported, asynchronous optional.
// RL19: Asynchronous mode adds or drops nulls.
// RL20: Free-running 32-bit counter at 10.24 MHz.
// RL21: Passthrough forwards packets unchanged otherwise.
// RL22: Insert sync within configured interval.
// RL23: Latch count at first byte plus offset.
`timescale 1ns/1ps
`include "dsync_map.svh"
module dsync_node (
   input  wire logic        i_clk,
   input  wire logic        i_reset_n,
   input  wire logic [1:0]  i_mode,
   input  wire logic        i_async,
   input  wire logic        i_tick_valid,
   input  wire logic [31:0] i_ref_time,
   input  wire logic [31:0] i_ts_offset,
   input  wire logic [31:0] i_sync_interval,
   input  wire logic        i_phy_ready,
   dsync_if.node            lnk,
   output logic             o_phy_valid,
   output logic             o_phy_sop,
   output logic [7:0]       o_phy_data,
   output logic             o_lag_err
);
   logic [15:0] mclk_acc_reg;
   logic        mclk_en;
   logic [31:0] ts_reg;
   logic [31:0] ts_next;
   logic [31:0] stamp_reg;
   logic [31:0] ivl_cnt_reg;
   logic        ins_due_reg;
   logic [7:0]  idx_reg;
   logic        pusi_reg;
   logic        is_sync_reg;
   logic        prev_zero_reg;
   logic        v_reg;
   logic        s_reg;
   logic [7:0]  d_reg;
   logic        lag_reg;
   logic [31:0] lag;
   logic        step;
   logic        fwd_take;
   dsync_pkg::dsync_state_t st_reg;

   function automatic logic [7:0] stamp_byte(input logic [31:0] t,
                                              input logic [7:0] i);
      logic [1:0] k;
      k = 2'(i - `DSYNC_TS_IDX);
      stamp_byte = t[8'd31 - {k, 3'b000} -: 8];
   endfunction : stamp_byte

   function automatic logic in_stamp(input logic [7:0] i);
      in_stamp = (i >= `DSYNC_TS_IDX) && (i < `DSYNC_TS_IDX + 8'd4);
   endfunction : in_stamp

   // Fractional divider gives a 10.24 MHz enable from the 40 MHz clock.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         mclk_acc_reg <= 16'h0000;
      end else if (mclk_acc_reg + `DSYNC_MCLK_ACC >= `DSYNC_MCLK_MOD) begin
         mclk_acc_reg <= mclk_acc_reg + `DSYNC_MCLK_ACC - `DSYNC_MCLK_MOD;
      end else begin
         mclk_acc_reg <= mclk_acc_reg + `DSYNC_MCLK_ACC;
      end
   end
   assign mclk_en = (mclk_acc_reg + `DSYNC_MCLK_ACC >= `DSYNC_MCLK_MOD);

   // Reloads from the reference so the lag stays fixed near one tick.
   assign ts_next = mclk_en ? ts_reg + 32'h1 : ts_reg; // [RL20]
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ts_reg <= 32'h0000_0000;
      end else if (i_tick_valid) begin
         ts_reg <= i_ref_time; // [RL1] [RL5]
      end else begin
         ts_reg <= ts_next; // [RL20]
      end
   end

   assign lag = i_ref_time - ts_reg;
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         lag_reg <= 1'b0;
      end else if (i_tick_valid) begin
         lag_reg <= (lag > 32'(`DSYNC_LAG_MAX)); // [RL5]
      end
   end
   assign o_lag_err = lag_reg;

   assign step = !o_phy_valid || i_phy_ready;
   // Ready follows the output slot, so a stalled modulator holds the link.
   assign lnk.ready = (st_reg == dsync_pkg::DSYNC_ST_FWD) && step;
   assign fwd_take = lnk.valid && lnk.ready;

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         ivl_cnt_reg <= 32'h0;
         ins_due_reg <= 1'b0;
      end else if (st_reg == dsync_pkg::DSYNC_ST_INS && idx_reg == 8'h0) begin
         ivl_cnt_reg <= 32'h0;
         ins_due_reg <= 1'b0;
      end else if (ivl_cnt_reg + 32'h1 >= i_sync_interval) begin
         ins_due_reg <= 1'b1; // [RL22]
      end else begin
         ivl_cnt_reg <= ivl_cnt_reg + 32'h1;
      end
   end

   // Idle chooses: insert a due sync, forward the headend, or pad a null.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         st_reg  <= dsync_pkg::DSYNC_ST_IDLE;
         idx_reg <= 8'h00;
      end else if (step) begin
         case (st_reg)
            dsync_pkg::DSYNC_ST_IDLE: begin
               idx_reg <= 8'h00;
               if (ins_due_reg &&
                   i_mode == dsync_pkg::DSYNC_MODE_STREAM) begin
                  st_reg <= dsync_pkg::DSYNC_ST_INS; // [RL3]
               end else if (lnk.valid && lnk.sop) begin
                  st_reg <= dsync_pkg::DSYNC_ST_FWD;
               end else if (i_async) begin
                  st_reg <= dsync_pkg::DSYNC_ST_NULL; // [RL19]
               end
            end
            dsync_pkg::DSYNC_ST_FWD: begin
               if (fwd_take) begin
                  idx_reg <= idx_reg + 8'h01;
                  if (idx_reg == `DSYNC_PKT_LEN - 8'h01) begin
                     st_reg <= dsync_pkg::DSYNC_ST_IDLE;
                  end
               end
            end
            default: begin
               idx_reg <= idx_reg + 8'h01;
               if (idx_reg == `DSYNC_PKT_LEN - 8'h01) begin
                  st_reg <= dsync_pkg::DSYNC_ST_IDLE;
               end
            end
         endcase
      end
   end

   // Header fields seen so far on the forwarded packet.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pusi_reg      <= 1'b0;
         is_sync_reg   <= 1'b0;
         prev_zero_reg <= 1'b0;
      end else if (fwd_take) begin
         if (idx_reg == 8'h00) begin
            is_sync_reg <= 1'b0;
         end
         if (idx_reg == 8'h01) begin
            pusi_reg <= lnk.data[6];
         end
         if (idx_reg == `DSYNC_PTR_IDX) begin
            prev_zero_reg <= (lnk.data == `DSYNC_MSG_TAG_HI);
         end
         if (idx_reg == `DSYNC_MSG_IDX) begin
            is_sync_reg <= pusi_reg && prev_zero_reg &&
                           (lnk.data == `DSYNC_MSG_TAG_LO); // [RL9]
         end
      end
   end

   // Stamp taken when the first message byte leaves, plus a fixed offset.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         stamp_reg <= 32'h0;
      end else if (step && idx_reg == `DSYNC_MSG_IDX &&
                   st_reg != dsync_pkg::DSYNC_ST_IDLE) begin
         stamp_reg <= ts_reg + i_ts_offset; // [RL6] [RL23]
      end
   end

   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         v_reg <= 1'b0;
         s_reg <= 1'b0;
         d_reg <= 8'h00;
      end else if (step) begin
         v_reg <= 1'b0;
         s_reg <= 1'b0;
         case (st_reg)
            dsync_pkg::DSYNC_ST_FWD: begin
               v_reg <= fwd_take;
               s_reg <= fwd_take && (idx_reg == 8'h00);
               d_reg <= lnk.data; // [RL21]
               if (is_sync_reg && in_stamp(idx_reg) &&
                   (i_mode != dsync_pkg::DSYNC_MODE_STREAM)) begin
                  d_reg <= stamp_byte(stamp_reg, idx_reg); // [RL2]
               end
               // Nulls pass whole: a cut packet would break the stream,
               // so back-pressure on the headend does the removal. [RL19]
            end
            dsync_pkg::DSYNC_ST_INS: begin
               v_reg <= 1'b1;
               s_reg <= (idx_reg == 8'h00);
               if (idx_reg == 8'h00) begin
                  d_reg <= `DSYNC_SYNC_BYTE;
               end else if (idx_reg == 8'h01) begin
                  d_reg <= 8'h40;
               end else if (idx_reg == `DSYNC_PTR_IDX) begin
                  d_reg <= `DSYNC_MSG_TAG_HI; // [RL4]
               end else if (idx_reg == `DSYNC_MSG_IDX) begin
                  d_reg <= `DSYNC_MSG_TAG_LO; // [RL4] [RL3]
               end else if (in_stamp(idx_reg)) begin
                  d_reg <= stamp_byte(stamp_reg, idx_reg); // [RL3]
               end else begin
                  d_reg <= 8'hff;
               end
            end
            dsync_pkg::DSYNC_ST_NULL: begin
               v_reg <= 1'b1;
               s_reg <= (idx_reg == 8'h00);
               if (idx_reg == 8'h00) begin
                  d_reg <= `DSYNC_SYNC_BYTE;
               end else if (idx_reg == 8'h01) begin
                  d_reg <= `DSYNC_NULL_PID_HI;
               end else if (idx_reg == 8'h02) begin
                  d_reg <= `DSYNC_NULL_PID_LO;
               end else begin
                  d_reg <= 8'hff; // [RL19]
               end
            end
            default: begin
               d_reg <= d_reg;
            end
         endcase
      end
   end
   // No buffer: bytes go straight through, far below the limits. [RL12]
   // Fixed pipeline depth keeps channels aligned. [RL13] [RL18]
   // Deep buffering lives upstream of this path. [RL14] [RL15]
   assign o_phy_valid = v_reg;
   assign o_phy_sop   = s_reg;
   assign o_phy_data  = d_reg;
endmodule : dsync_node

// *** dv/dsync_link_sva.sv ***
// Checker for the transport byte stream between headend and node.
`timescale 1ns/1ps
module dsync_link_sva (
   input wire logic       i_clk,
   input wire logic       i_reset_n,
   input wire logic       valid,
   input wire logic       ready,
   input wire logic       sop,
   input wire logic [7:0] data
);
   logic       take;
   logic [7:0] cnt_reg;
   logic       pusi_reg;
   logic [7:0] ptr_reg;
   logic       sync_reg;
   assign take = valid && ready;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_reset_n);
   // Byte position inside the current 188-byte packet.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n)
         cnt_reg <= 8'h00;
      else if (take)
         cnt_reg <= (cnt_reg == 8'hbb) ? 8'h00 : cnt_reg + 8'h01;
   end
   // Header fields kept so later bytes can be judged against them.
   always_ff @(posedge i_clk or negedge i_reset_n) begin
      if (!i_reset_n) begin
         pusi_reg <= 1'b0;
         ptr_reg  <= 8'h00;
         sync_reg <= 1'b0;
      end else if (take) begin
         if (cnt_reg == 8'h01) pusi_reg <= data[6];
         if (cnt_reg == 8'h04) ptr_reg <= data;
         if (cnt_reg == 8'h05)
            sync_reg <= pusi_reg && ptr_reg == 8'h00 && data == 8'hc0;
      end
   end
   a_start_flag: assert property (
      take && cnt_reg == 8'h00 |-> sop) else $error("start flag missing");
   a_start_only: assert property (
      valid && sop |-> cnt_reg == 8'h00) else $error("start flag mid packet");
   a_start_byte: assert property (
      valid && sop |-> data == 8'h47) else $error("bad first byte");
   a_valid_held: assert property (
      valid && !ready |=> valid) else $error("request dropped");
   a_data_held: assert property (
      valid && !ready |=> $stable(data) && $stable(sop))
      else $error("data moved while stalled");
   a_stamp_zero: assert property (
      take && sync_reg && cnt_reg >= 8'h18 && cnt_reg <= 8'h1b
      |-> data == 8'h00) else $error("sync stamp not zero");
   // Only sync messages start a payload behind a zero pointer on this link.
   a_ptr_before: assert property (
      take && cnt_reg == 8'h05 && pusi_reg && ptr_reg == 8'h00
      |-> data == 8'hc0) else $error("sync tag not after pointer");
   a_quiet_start: assert property (
      $rose(i_reset_n) |-> !valid [*2]) else $error("link busy at start");
endmodule : dsync_link_sva

// *** dv/tb.sv ***
// Self-checking bench for the headend and node pair.
`timescale 1ns/1ps
`include "dsync_map.svh"
module tb;
   localparam logic [31:0] REF = 32'h0001_0000;
   localparam logic [31:0] OFS = 32'h0000_0010;
   logic [31:0] ref_time;
   logic       i_clk, i_reset_n, i_async, tick, i_phy_ready, stall;
   logic [1:0] mode;
   logic       pkt_valid, pkt_sync, pkt_sop, pkt_ready;
   logic [7:0] pkt_byte, phy_data;
   logic       phy_valid, phy_sop, lag_err;
   logic [7:0] rx[188];
   logic [7:0] tx[188];
   int         error_cnt, compares, cyc, tick_cyc, rx_n, rx_cnt;
   int         sop_cyc, end_cyc, t, m;
   dsync_if lnk();
   dsync_headend dsync_headend_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_mode(mode),
      .i_pkt_valid(pkt_valid), .i_pkt_is_sync(pkt_sync),
      .i_pkt_byte(pkt_byte), .i_pkt_sop(pkt_sop),
      .o_pkt_ready(pkt_ready), .lnk(lnk));
   dsync_node dsync_node_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .i_mode(mode),
      .i_async(i_async), .i_tick_valid(tick), .i_ref_time(ref_time),
      .i_ts_offset(OFS), .i_sync_interval(32'h0000_0190),
      .i_phy_ready(i_phy_ready), .lnk(lnk), .o_phy_valid(phy_valid),
      .o_phy_sop(phy_sop), .o_phy_data(phy_data), .o_lag_err(lag_err));
   dsync_link_sva dsync_link_sva_inst (
      .i_clk(i_clk), .i_reset_n(i_reset_n), .valid(lnk.valid),
      .ready(lnk.ready), .sop(lnk.sop), .data(lnk.data));
   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end
   // Collects bytes the modulator side accepts, one packet at a time.
   always @(posedge i_clk) begin
      cyc++;
      if (phy_valid === 1'b1 && i_phy_ready) begin
         if (phy_sop === 1'b1) begin
            rx_n = 0;
            sop_cyc = cyc;
         end
         if (rx_n < 188) rx[rx_n] = phy_data;
         rx_n++;
         if (rx_n == 188) rx_cnt++;
      end
   end
   // Periodic back-pressure so the node must hold its outputs.
   always @(negedge i_clk) i_phy_ready <= !stall || (cyc % 3 != 0);
   task automatic chk(input logic ok, input string msg);
      compares++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("CHECK FAILED t=%0t %s", $time, msg);
      end
   endtask : chk
   task automatic test_done;
      $display("compares=%0d mismatches=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : test_done
   function automatic logic [1:0] kind_of();
      if (rx[1][4:0] == 5'h1f && rx[2] == 8'hff) return 2'd2;
      if (rx[1][6] && rx[4] == 8'h00 && rx[5] == 8'hc0) return 2'd1;
      return 2'd0;
   endfunction : kind_of
   task automatic send_pkt(input logic s, input logic [7:0] seed);
      int  i, n;
      logic r;
      for (i = 0; i < 188; i++) tx[i] = i[7:0] ^ seed;
      tx[0] = 8'h47;
      tx[1] = s ? 8'h41 : 8'h01;
      tx[2] = 8'h00;
      if (s) begin
         tx[4] = 8'h00;
         tx[5] = 8'hc0;
      end
      i = 0;
      r = 1'b0;
      for (n = 0; n < 20000 && i < 188; n++) begin
         @(negedge i_clk);
         if (r) i++;
         pkt_valid = (i < 188);
         pkt_sync = s;
         pkt_sop = (i == 0);
         pkt_byte = tx[i % 188];
         r = (pkt_ready === 1'b1);
      end
      pkt_valid = 1'b0;
      end_cyc = cyc;
      if (i < 188) begin
         chk(1'b0, "headend never took packet");
         test_done();
      end
   endtask : send_pkt
   task automatic wait_pkt(input logic [1:0] k);
      int seen, n;
      seen = rx_cnt;
      for (n = 0; n < 20000; n++) begin
         @(negedge i_clk);
         if (rx_cnt != seen) begin
            seen = rx_cnt;
            if (kind_of() == k) return;
         end
      end
      chk(1'b0, "packet wait timed out");
      test_done();
   endtask : wait_pkt
   task automatic chk_fwd(input logic s);
      int i, bad;
      bad = 0;
      for (i = 0; i < 188; i++)
         if (rx[i] !== tx[i] && !(s && i >= 24 && i <= 27)) bad++;
      chk(bad == 0, "forwarded bytes differ");
   endtask : chk_fwd
   // The stamp is the count near the packet start; the node may lag a bit.
   task automatic chk_stamp;
      int el, got;
      el = (sop_cyc - tick_cyc) * 256 / 1000;
      got = {rx[24], rx[25], rx[26], rx[27]} - ref_time - OFS;
      chk(got >= el - 110 && got <= el + 10, "stamp out of range");
   endtask : chk_stamp
   initial begin
      i_reset_n = 1'b0;
      ref_time = REF;
      {i_async, tick, stall, pkt_valid, pkt_sync, pkt_sop} = 6'h00;
      mode = 2'b00;
      pkt_byte = 8'h00;
      repeat (5) @(negedge i_clk);
      i_reset_n = 1'b1;
      repeat (2) @(negedge i_clk);
      // The first tick meets a counter far behind; the second finds it level.
      tick = 1'b1;
      @(negedge i_clk);
      chk(lag_err === 1'b1, "lag flag not set");
      @(negedge i_clk);
      tick = 1'b0;
      tick_cyc = cyc;
      chk(lag_err === 1'b0, "lag flag set");
      $display("lag test done");
      for (m = 0; m < 2; m++) begin
         mode = m[1:0];
         stall = 1'b1;
         send_pkt(1'b1, 8'h5a);
         wait_pkt(2'd1);
         chk_fwd(1'b1);
         chk_stamp();
         send_pkt(1'b0, 8'h33);
         wait_pkt(2'd0);
         chk_fwd(1'b0);
         chk(sop_cyc - end_cyc < `DSYNC_LATENCY_CYC, "slow");
         $display("forwarding test in mode %0d done", m);
      end
      mode = 2'b10;
      stall = 1'b0;
      wait_pkt(2'd1);
      t = sop_cyc;
      chk(rx[0] === 8'h47 && rx[4] === 8'h00, "bad insert");
      chk_stamp();
      wait_pkt(2'd1);
      chk(sop_cyc - t <= 600, "insert gap too long");
      $display("insertion test done");
      mode = 2'b00;
      i_async = 1'b1;
      wait_pkt(2'd2);
      chk(rx[0] === 8'h47 && rx[3][4] === 1'b1, "bad pad");
      i_async = 1'b0;
      $display("padding test done");
      test_done();
   end
endmodule : tb
